/* File: hdl/dbma_pkg.sv */
package dbma_pkg;

  // ****************************************************************
  // arbitration timing; the two delays count system bus clock edges, SYNC_STAGES counts ref_clk flops
  // ****************************************************************
  localparam int unsigned SYNC_STAGES       = 2;
  // rising edges from grant-high sample to request low
  localparam int unsigned REQ_RISE_DELAY    = 2;
  // falling edges from ownership sample to first bus phase
  localparam int unsigned START_FALL_DELAY  = 2;
  localparam int unsigned EDGE_CNT_W        = 2;

  // ****************************************************************
  // reset values of the driven pins
  // ****************************************************************
  localparam logic RST_BUS_OWNED_N   = 1'b1;
  localparam logic RST_BUS_REQUEST_N = 1'b1;

  // ****************************************************************
  // arbiter states
  // ****************************************************************
  typedef enum logic [6:0] {
    DBMA_IDLE    = 7'b0000001,
    DBMA_CHK_GNT = 7'b0000010,
    DBMA_REQ_DLY = 7'b0000100,
    DBMA_WAIT    = 7'b0001000,
    DBMA_START   = 7'b0010000,
    DBMA_OWN     = 7'b0100000,
    DBMA_RELEASE = 7'b1000000
  } dbma_state_e;

  // odd parity: the parity bit makes the count of ones odd
  function automatic logic dbma_odd_par(input logic [7:0] b);
    dbma_odd_par = ~(^b);
  endfunction : dbma_odd_par

endpackage : dbma_pkg

/* File: hdl/dbma_edge_if.sv */
`timescale 1ns/1ps
// carries the sampled link clock edges between the detector and the arbiter
interface dbma_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : dbma_edge_if

/* File: hdl/dbma_clk_edge.sv */
`timescale 1ns/1ps
module dbma_clk_edge
  import dbma_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // raw link clock pin
  input  wire logic system_bus_clock,
  // detected edges
  dbma_edge_if.src  edge_o
);

  // ****************************************************************
  // two-stage sampling of the link clock, then edge detect
  // ****************************************************************
  logic [SYNC_STAGES-1:0] sync_r;
  logic                   last_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[SYNC_STAGES-2:0], system_bus_clock};
    end
  end

  // only the last stage is looked at
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_r <= 1'b0;
    end else begin
      last_r <= sync_r[SYNC_STAGES-1];
    end
  end

  assign edge_o.rise = sync_r[SYNC_STAGES-1] & ~last_r;
  assign edge_o.fall = ~sync_r[SYNC_STAGES-1] & last_r;

endmodule : dbma_clk_edge

/* File: hdl/dbma_arbiter.sv */
`timescale 1ns/1ps
module dbma_arbiter
  import dbma_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link clock pin, sampled like any other input
  input  wire logic        system_bus_clock,
  // arbitration pins
  output logic             bus_request_n,
  output logic             bus_owned_n,
  input  wire logic        bus_grant_n,
  input  wire logic        bus_busy_n,
  input  wire logic        bus_release_n,
  input  wire logic        bus_error_n,
  // bus state pins watched before taking the bus
  input  wire logic        address_strobe_n,
  input  wire logic        upper_data_strobe_n,
  input  wire logic        lower_data_strobe_n,
  input  wire logic        transfer_ack_n,
  // address/data lanes
  output logic [0:7]       addr_data_high_lane,
  output logic [0:7]       addr_data_low_lane,
  output logic             parity_high_lane,
  output logic             parity_low_lane,
  // user side: dma engine
  input  wire logic        dma_req,
  input  wire logic        dma_burst,
  input  wire logic        dma_last,
  input  wire logic [15:0] dma_word,
  output logic             dma_start,
  output logic             dma_owned,
  output logic             dma_abort
);

  // ****************************************************************
  // link clock edges
  // ****************************************************************
  dbma_edge_if edge_if ();

  dbma_clk_edge u_edge (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .system_bus_clock (system_bus_clock),
    .edge_o           (edge_if)
  );

  // ****************************************************************
  // pin synchronizers: two stages each, only stage two is read
  // ****************************************************************
  localparam int unsigned NIN = 8;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] pin_s1_r;
  logic [NIN-1:0] pin_s2_r;

  assign pin_raw = {bus_grant_n, bus_busy_n, bus_release_n, bus_error_n,
                    address_strobe_n, upper_data_strobe_n,
                    lower_data_strobe_n, transfer_ack_n};

  // all pins idle high, so reset loads ones; a floating busy pin also
  // reads high through the pad pull-up
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ****************************************************************
  // falling-edge samples of the link pins
  // ****************************************************************
  logic gnt_n_r;
  logic bsy_n_r;
  logic rls_n_r;
  logic err_n_r;
  logic as_n_r;
  logic uds_n_r;
  logic lds_n_r;
  logic ack_n_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {gnt_n_r, bsy_n_r, rls_n_r, err_n_r,
       as_n_r, uds_n_r, lds_n_r, ack_n_r} <= '1;
    end else if (edge_if.fall) begin
      {gnt_n_r, bsy_n_r, rls_n_r, err_n_r,
       as_n_r, uds_n_r, lds_n_r, ack_n_r} <= pin_s2_r;
    end
  end

  // one cycle after a falling edge the fresh sample is in the flops
  logic samp_vld_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      samp_vld_r <= 1'b0;
    end else begin
      samp_vld_r <= edge_if.fall;
    end
  end

  logic own_ok;
  // request low is our own output, the rest come from the sample
  assign own_ok = ~bus_request_n & ~gnt_n_r & bsy_n_r & err_n_r
                & as_n_r & uds_n_r & lds_n_r & ack_n_r;

  // ****************************************************************
  // arbiter state machine
  // ****************************************************************
  dbma_state_e             state_r;
  dbma_state_e             state_nxt;
  logic [EDGE_CNT_W-1:0]   cnt_r;
  logic                    burst_r;
  logic                    rerq_r;

  logic dma_want;
  assign dma_want = dma_req | rerq_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DBMA_IDLE: begin
        if (dma_want) begin
          state_nxt = DBMA_CHK_GNT;
        end
      end
      DBMA_CHK_GNT: begin
        if (samp_vld_r && gnt_n_r) begin
          state_nxt = DBMA_REQ_DLY;
        end
      end
      DBMA_REQ_DLY: begin
        if (edge_if.rise && cnt_r == EDGE_CNT_W'(REQ_RISE_DELAY - 1)) begin
          state_nxt = DBMA_WAIT;
        end
      end
      DBMA_WAIT: begin
        if (samp_vld_r && own_ok) begin
          state_nxt = DBMA_START;
        end
      end
      DBMA_START: begin
        if (edge_if.fall && cnt_r == EDGE_CNT_W'(START_FALL_DELAY - 1)) begin
          state_nxt = DBMA_OWN;
        end
      end
      DBMA_OWN: begin
        if (samp_vld_r && !err_n_r) begin
          state_nxt = DBMA_RELEASE;
        end else if (samp_vld_r && burst_r && !rls_n_r) begin
          state_nxt = DBMA_RELEASE;
        end else if (dma_last) begin
          state_nxt = DBMA_RELEASE;
        end
      end
      DBMA_RELEASE: begin
        if (edge_if.rise) begin
          state_nxt = DBMA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= DBMA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // edge counter, cleared whenever the state changes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if ((state_r == DBMA_REQ_DLY && edge_if.rise) ||
                 (state_r == DBMA_START && edge_if.fall)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // burst flag latched when a request leaves idle; release only counts in burst mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      burst_r <= 1'b0;
    end else if (state_r == DBMA_IDLE && dma_want) begin
      burst_r <= dma_burst & ~rerq_r;
    end
  end

  // after a release forced by the release pin (not by a bus error) the bus is asked for again straight away,
  // now as cycle-steal so a second release cannot bounce us
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rerq_r <= 1'b0;
    end else if (state_r == DBMA_OWN && state_nxt == DBMA_RELEASE) begin
      rerq_r <= err_n_r & burst_r & ~rls_n_r;
    end else if (state_r == DBMA_OWN) begin
      rerq_r <= 1'b0;
    end
  end

  // ****************************************************************
  // pin drivers, changed on rising link clock edges only
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_request_n <= RST_BUS_REQUEST_N;
    end else if (edge_if.rise) begin
      if (state_r == DBMA_REQ_DLY &&
          cnt_r == EDGE_CNT_W'(REQ_RISE_DELAY - 1)) begin
        bus_request_n <= 1'b0;
      end else if (state_r == DBMA_OWN && !bus_owned_n &&
                   !bsy_n_r) begin
        // grant acknowledge now held by glue, request may go
        bus_request_n <= 1'b1;
      end else if (state_r == DBMA_RELEASE || state_r == DBMA_IDLE) begin
        bus_request_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_owned_n <= RST_BUS_OWNED_N;
    end else if (edge_if.rise) begin
      if (state_r == DBMA_OWN) begin
        bus_owned_n <= 1'b0;
      end else begin
        bus_owned_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // lanes and parity; bit 15 of the word goes to high lane index 0
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_data_high_lane <= 8'h00;
      addr_data_low_lane  <= 8'h00;
      parity_high_lane    <= 1'b1;
      parity_low_lane     <= 1'b1;
    end else if (edge_if.rise) begin
      addr_data_high_lane <= dma_word[15:8];
      addr_data_low_lane  <= dma_word[7:0];
      parity_high_lane    <= dbma_odd_par(dma_word[15:8]);
      parity_low_lane     <= dbma_odd_par(dma_word[7:0]);
    end
  end

  // ****************************************************************
  // user-side status
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dma_start <= 1'b0;
      dma_owned <= 1'b0;
      dma_abort <= 1'b0;
    end else begin
      dma_start <= (state_r == DBMA_START) && (state_nxt == DBMA_OWN);
      dma_owned <= (state_nxt == DBMA_OWN);
      dma_abort <= (state_r == DBMA_OWN) && samp_vld_r && !err_n_r;
    end
  end

endmodule : dbma_arbiter

/* File: tb/dbma_host_model.sv */
`timescale 1ns/1ps
// ******
// host processor and arbitration glue
// ******
module dbma_host_model (
  // link clock and reset
  input  wire logic system_bus_clock,
  input  wire logic rst,
  // slow host yields the grant two link cycles late
  input  wire logic slow,
  // device pins
  input  wire logic bus_request_n,
  input  wire logic bus_owned_n,
  output logic      bus_grant_n,
  output logic      bus_busy_n
);
  logic [1:0] dly_r;
  // glue holds grant acknowledge low while the device owns the bus,
  // so no other master can take it meanwhile
  assign bus_busy_n = bus_owned_n;
  always_ff @(posedge system_bus_clock or posedge rst) begin
    if (rst || bus_request_n) begin
      dly_r <= 2'h0;
    end else if (dly_r != 2'h3) begin
      dly_r <= dly_r + 2'h1;
    end
  end
  always_ff @(posedge system_bus_clock or posedge rst) begin
    if (rst || bus_request_n) begin
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= !(dly_r >= (slow ? 2'h2 : 2'h0));
    end
  end
endmodule : dbma_host_model

/* File: tb/dbma_arbiter_properties.sv */
`timescale 1ns/1ps
module dbma_arbiter_properties (
  // clock and reset
  input logic       ref_clk,
  input logic       rst,
  // link clock and pins
  input logic       system_bus_clock,
  input logic       bus_request_n,
  input logic       bus_owned_n,
  input logic       bus_busy_n,
  input logic       bus_error_n,
  input logic [0:7] addr_data_high_lane,
  input logic [0:7] addr_data_low_lane,
  input logic       parity_high_lane,
  input logic       parity_low_lane,
  // user side
  input logic       dma_start,
  input logic       dma_abort
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_own_with_req: assert property ($fell(bus_owned_n) |-> !bus_request_n)
    else $error("bus taken without request");
  a_busy_before_own: assert property ($fell(bus_owned_n) |-> $past(bus_busy_n, 12))
    else $error("bus taken while busy");
  a_start_then_own: assert property (dma_start |-> ##[1:10] $fell(bus_owned_n))
    else $error("no bus owned after start");
  a_start_pulse: assert property (dma_start |=> !dma_start [*3])
    else $error("start pulse too long");
  // a changed pin must sit shortly after a link rising edge; the raw
  // clock is still high two samples back given the sync latency
  a_owned_on_rise: assert property ($changed(bus_owned_n) |-> $past(system_bus_clock, 2))
    else $error("bus owned moved off rising edge");
  a_req_on_rise: assert property ($changed(bus_request_n) |-> $past(system_bus_clock, 2))
    else $error("request moved off rising edge");
  a_error_abort: assert property (!bus_owned_n && $fell(bus_error_n) |-> ##[1:20] dma_abort)
    else $error("bus error not aborted");
  a_abort_frees: assert property (dma_abort |-> ##[0:12] bus_owned_n)
    else $error("bus kept after abort");
  a_parity_high: assert property (parity_high_lane == ~(^addr_data_high_lane))
    else $error("high lane parity wrong");
  a_parity_low: assert property (parity_low_lane == ~(^addr_data_low_lane))
    else $error("low lane parity wrong");
endmodule : dbma_arbiter_properties
bind dbma_arbiter dbma_arbiter_properties u_props (
  .ref_clk, .rst, .system_bus_clock, .bus_request_n, .bus_owned_n,
  .bus_busy_n, .bus_error_n, .addr_data_high_lane, .addr_data_low_lane,
  .parity_high_lane, .parity_low_lane, .dma_start, .dma_abort
);

/* File: tb/dbma_arbiter_tb.sv */
`timescale 1ns/1ps
module dbma_arbiter_tb;
  logic        ref_clk, rst, system_bus_clock, slow;
  logic        dma_req, dma_burst, dma_last, bus_release_n;
  logic [15:0] dma_word;
  logic [5:0]  hold_n;
  logic        bus_request_n, bus_owned_n, bus_grant_n, busy_glue_n;
  logic        bus_busy_n, bus_error_n, address_strobe_n;
  logic        upper_data_strobe_n, lower_data_strobe_n, transfer_ack_n;
  logic [0:7]  addr_data_high_lane, addr_data_low_lane;
  logic        parity_high_lane, parity_low_lane;
  logic        dma_start, dma_owned, dma_abort;
  int          mismatches, checks;
  // one low bit of hold_n blocks ownership: busy, error, strobes, ack
  assign bus_busy_n = busy_glue_n & hold_n[5];
  assign {bus_error_n, address_strobe_n, upper_data_strobe_n,
          lower_data_strobe_n, transfer_ack_n} = hold_n[4:0];
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // free-running link oscillator, phase unrelated to ref_clk
  initial begin
    system_bus_clock = 1'b0;
    #7;
    forever #100 system_bus_clock = ~system_bus_clock;
  end
  dbma_arbiter uut (
    .ref_clk, .rst, .system_bus_clock, .bus_request_n, .bus_owned_n,
    .bus_grant_n, .bus_busy_n, .bus_release_n, .bus_error_n,
    .address_strobe_n, .upper_data_strobe_n, .lower_data_strobe_n,
    .transfer_ack_n, .addr_data_high_lane, .addr_data_low_lane,
    .parity_high_lane, .parity_low_lane, .dma_req, .dma_burst, .dma_last,
    .dma_word, .dma_start, .dma_owned, .dma_abort
  );
  dbma_host_model host (
    .system_bus_clock, .rst, .slow, .bus_request_n, .bus_owned_n,
    .bus_grant_n, .bus_busy_n(busy_glue_n)
  );
  task automatic conclude();
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask : check
  task automatic wait_own(input logic lvl);
    int n;
    for (n = 0; n < 600 && bus_owned_n !== lvl; n++) @(posedge ref_clk);
    if (n == 600) begin
      $display("[ERR] %0t bus owned wait ran out", $time);
      mismatches++;
      conclude();
    end
  endtask : wait_own
  task automatic stay(input logic lvl, input int cyc);
    repeat (cyc) begin
      @(posedge ref_clk);
      check(bus_owned_n, lvl);
    end
  endtask : stay
  task automatic own_bus(input logic burst);
    int n;
    dma_burst <= burst;
    dma_req   <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 600 && dma_start !== 1'b1; n++) @(posedge ref_clk);
    check(dma_start, 1'b1);
    wait_own(1'b0);
    dma_req <= 1'b0;
  endtask : own_bus
  task automatic free_bus();
    dma_last <= 1'b1;
    wait_own(1'b1);
    check(bus_request_n, 1'b1);
    dma_last <= 1'b0;
    repeat (40) @(posedge ref_clk);
  endtask : free_bus
  task automatic t_lanes();
    dma_word <= 16'hA7C3;
    own_bus(1'b1);
    check(bus_request_n, 1'b0);
    repeat (40) @(posedge ref_clk);
    check({addr_data_high_lane, addr_data_low_lane}, 16'hA7C3);
    check({parity_high_lane, parity_low_lane}, {~^8'hA7, ~^8'hC3});
    check(bus_request_n, 1'b1);
    check(dma_owned, 1'b1);
    stay(1'b0, 40);
    free_bus();
  endtask : t_lanes
  // release in burst drops the bus; the re-request is cycle-steal,
  // so a release still held low must then be ignored
  task automatic t_release();
    slow <= 1'b1;
    own_bus(1'b1);
    bus_release_n <= 1'b0;
    wait_own(1'b1);
    wait_own(1'b0);
    stay(1'b0, 80);
    bus_release_n <= 1'b1;
    slow <= 1'b0;
    free_bus();
  endtask : t_release
  task automatic t_idle();
    bus_release_n <= 1'b0;
    stay(1'b1, 80);
    check(bus_request_n, 1'b1);
    bus_release_n <= 1'b1;
  endtask : t_idle
  task automatic t_error();
    int n;
    own_bus(1'b0);
    hold_n[4] <= 1'b0;
    for (n = 0; n < 100 && dma_abort !== 1'b1; n++) @(posedge ref_clk);
    check(dma_abort, 1'b1);
    wait_own(1'b1);
    hold_n[4] <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask : t_error
  task automatic t_blocks();
    for (int i = 0; i < 6; i++) begin
      hold_n  <= ~(6'h01 << i);
      dma_req <= 1'b1;
      stay(1'b1, 120);
      hold_n <= 6'h3F;
      wait_own(1'b0);
      dma_req <= 1'b0;
      free_bus();
    end
  endtask : t_blocks
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    {dma_req, dma_burst, dma_last} = 3'h0;
    bus_release_n = 1'b1;
    dma_word = 16'h0000;
    hold_n = 6'h3F;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (40) @(posedge ref_clk);
    t_lanes();
    t_release();
    t_idle();
    t_error();
    t_blocks();
    conclude();
  end
endmodule : dbma_arbiter_tb
